// [rtl/ufb_map.vh]
// Purpose: Register offsets, field positions, reset values and timing for the frame/baud block
// Assumes: Wishbone byte addresses, one register per aligned 32-bit word
// Notes:   Included by the core design file only
`ifndef UFB_MAP_VH
`define UFB_MAP_VH

// Register byte offsets
`define UFB_OFF_SHARED    4'h0
`define UFB_OFF_DIV_LOW   4'h4
`define UFB_OFF_CTRL_B    4'h8
`define UFB_OFF_STATUS    4'hC

// Shared location fields
`define UFB_SEL_BIT       7
`define UFB_MODE_BIT      6
`define UFB_PAR_HI        5
`define UFB_PAR_LO        4
`define UFB_STOP_BIT      3
`define UFB_CSZ_HI        2
`define UFB_CSZ_LO        1
`define UFB_POL_BIT       0

// Control B fields
`define UFB_CB_DBL_BIT    0
`define UFB_CB_CSZ2_BIT   1
`define UFB_CB_MASK_LO    4
`define UFB_CB_MASK_HI    5

// Status fields (sticky, write one to clear)
`define UFB_ST_PERR_BIT   0
`define UFB_ST_DIVLD_BIT  1

// Reset values
`define UFB_FRAME_RST     7'h06
`define UFB_DIV_RST       12'h000

// Oversampling ratios
`define UFB_OVS_NORMAL    5'h10
`define UFB_OVS_DOUBLE    5'h08

`endif

// [rtl/ufb_tick_div.v]
// Purpose: Reloadable down-counter that emits a one-cycle enable every (div+1) clocks
// Assumes: One clock domain, synchronous active-low reset
// Notes:   A reload pulse restarts the count at once with the new divisor
`timescale 1ns/1ps
module ufb_tick_div #(
   parameter W = 12
) (
   input  wire         mclk_i,
   input  wire         rst_n_i,
   input  wire         reload_i,
   input  wire [W-1:0] div_i,
   output reg          tick_o
);
   reg [W-1:0] cnt_r;   // Remaining clocks to next tick

   // Count down, tick on zero, reload on request
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         cnt_r  <= {W{1'b0}};
         tick_o <= 1'b0;
      end else if (reload_i) begin
         cnt_r  <= div_i;
         tick_o <= 1'b0;
      end else if (cnt_r == {W{1'b0}}) begin
         cnt_r  <= div_i;
         tick_o <= 1'b1;
      end else begin
         cnt_r  <= cnt_r - {{(W-1){1'b0}}, 1'b1};
         tick_o <= 1'b0;
      end
   end
endmodule // ufb_tick_div

// [rtl/ufb_core.v]
// Purpose: Frame format and baud divisor configuration with a small serial engine
// Assumes: Classic Wishbone slave, 250 MHz mclk_i, pins sampled by three flops
// Notes:   Transmit/receive data path is minimal; data enters on tx_data_i
//
// How it works
// - Bit 7 of a shared write picks register
// - Frame register reads select bit as one
// - Divisor high reads select bit as zero
// - Mode bit: 0 asynchronous, 1 synchronous
// - Parity field: off, reserved, even, odd
// - Transmitter appends computed parity bit
// - Receiver checks parity, flags error
// - Stop select: one or two stop bits
// - Receiver ignores stop select
// - Character size code 5..9 bits
// - Clock polarity picks sync edges
// - Divisor is 12 bits, high nibble plus low
// - Low write reloads prescaler at once
// - Async divides by 16, or 8 doubled
`timescale 1ns/1ps
`include "ufb_map.vh"
module ufb_core (
   input  wire        mclk_i,
   input  wire        rst_n_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [3:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output reg         wb_err_o,
   input  wire        tx_start_i,
   input  wire [8:0]  tx_data_i,
   output reg         tx_busy_o,
   output reg         txd_o,
   input  wire        rxd_i,
   input  wire        xck_i,
   output reg  [8:0]  rx_data_o,
   output reg         rx_valid_o,
   output reg         irq_o
);
   // State codes, one-hot
   localparam ST_IDLE  = 4'b0001;
   localparam ST_START = 4'b0010;
   localparam ST_DATA  = 4'b0100;
   localparam ST_STOP  = 4'b1000;

   reg  [6:0]  frame_r;        // Mode, parity, stop, size low, polarity
   reg  [3:0]  div_hi_r;       // Divisor high nibble
   reg  [7:0]  div_lo_r;       // Divisor low byte
   reg         dbl_r;          // Double speed
   reg         csz2_r;         // Character size high bit
   reg  [1:0]  mask_r;         // Interrupt mask
   reg  [1:0]  stat_r;         // Sticky events
   reg         reload_r;       // Prescaler reload pulse
   wire        ptick;          // Prescaler output enable
   wire [11:0] div_val = {div_hi_r, div_lo_r};
   wire [11:0] div_rst = `UFB_DIV_RST;        // Reset divisor, split below

   // Bus decode
   wire        req   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   wire        wr_b0 = req & wb_we_i & wb_sel_i[0];
   wire        map   = (wb_adr_i == `UFB_OFF_SHARED) | (wb_adr_i == `UFB_OFF_DIV_LOW)
                     | (wb_adr_i == `UFB_OFF_CTRL_B) | (wb_adr_i == `UFB_OFF_STATUS);

   // Decoded configuration
   wire        sync_mode = frame_r[`UFB_MODE_BIT];
   wire        par_en    = frame_r[`UFB_PAR_HI];
   wire        par_odd   = frame_r[`UFB_PAR_LO];
   wire        two_stop  = frame_r[`UFB_STOP_BIT];
   wire [2:0]  csz       = {csz2_r, frame_r[`UFB_CSZ_HI:`UFB_CSZ_LO]};
   reg  [3:0]  nbits;          // Data bits per character

   // Size code to bit count; reserved codes fall back to 8
   always @* begin
      case (csz)
         3'h0:    nbits = 4'h5;
         3'h1:    nbits = 4'h6;
         3'h2:    nbits = 4'h7;
         3'h7:    nbits = 4'h9;
         default: nbits = 4'h8;
      endcase
   end

   // Register writes; bit 7 of the shared word routes the byte
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         frame_r  <= `UFB_FRAME_RST;
         div_hi_r <= div_rst[11:8];
         div_lo_r <= div_rst[7:0];
         dbl_r    <= 1'b0;
         csz2_r   <= 1'b0;
         mask_r   <= 2'h0;
         reload_r <= 1'b0;
      end else begin
         reload_r <= 1'b0;
         if (wr_b0 && wb_adr_i == `UFB_OFF_SHARED) begin
            if (wb_dat_i[`UFB_SEL_BIT])
               frame_r <= wb_dat_i[6:0];
            else
               div_hi_r <= wb_dat_i[3:0];
         end
         if (wr_b0 && wb_adr_i == `UFB_OFF_DIV_LOW) begin
            div_lo_r <= wb_dat_i[7:0];
            reload_r <= 1'b1;
         end
         if (wr_b0 && wb_adr_i == `UFB_OFF_CTRL_B) begin
            dbl_r  <= wb_dat_i[`UFB_CB_DBL_BIT];
            csz2_r <= wb_dat_i[`UFB_CB_CSZ2_BIT];
            mask_r <= wb_dat_i[`UFB_CB_MASK_HI:`UFB_CB_MASK_LO];
         end
      end
   end

   // Read mux and ack; shared location reads frame view (no read-select state)
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req & map;
         wb_err_o <= req & ~map;
         wb_dat_o <= 32'h0000_0000;
         if (req && !wb_we_i) begin
            case (wb_adr_i)
               `UFB_OFF_SHARED:  wb_dat_o <= {24'h0, 1'b1, frame_r};
               `UFB_OFF_DIV_LOW: wb_dat_o <= {24'h0, div_lo_r};
               `UFB_OFF_CTRL_B:  wb_dat_o <= {26'h0, mask_r, 2'h0, csz2_r, dbl_r};
               `UFB_OFF_STATUS:  wb_dat_o <= {16'h0, 1'b0, 3'h0, div_hi_r, 6'h0, stat_r};
               default:          wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
   // Status bits 15:8 mirror the high register: select 0 reserved zero

   // Prescaler, reloaded immediately by a low-byte write
   ufb_tick_div #(
      .W (12)
   ) u_pre (
      .mclk_i   (mclk_i),
      .rst_n_i  (rst_n_i),
      .reload_i (reload_r),
      .div_i    (div_val),
      .tick_o   (ptick)
   );

   // Oversample counter: async bit enable every 16 or 8 prescaler ticks
   reg  [4:0] ovs_r;           // Oversample count
   reg        bit_en_r;        // One-cycle bit enable
   wire [4:0] ovs_top = dbl_r ? `UFB_OVS_DOUBLE : `UFB_OVS_NORMAL;
   always @(posedge mclk_i) begin
      if (!rst_n_i || reload_r) begin
         ovs_r    <= 5'h00;
         bit_en_r <= 1'b0;
      end else begin
         bit_en_r <= 1'b0;
         if (ptick) begin
            if (ovs_r == ovs_top - 5'h01) begin
               ovs_r    <= 5'h00;
               bit_en_r <= 1'b1;
            end else begin
               ovs_r <= ovs_r + 5'h01;
            end
         end
      end
   end

   // Pin synchronisers, three flops; change accepted when 2nd and 3rd agree
   reg [2:0] rxd_s;            // Receive line sync chain
   reg [2:0] xck_s;            // External clock sync chain
   reg       rxd_f;            // Filtered receive level
   reg       xck_f;            // Filtered external clock
   reg       xck_d;            // Previous filtered clock
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rxd_s <= 3'h7;
         xck_s <= 3'h0;
         rxd_f <= 1'b1;
         xck_f <= 1'b0;
         xck_d <= 1'b0;
      end else begin
         rxd_s <= {rxd_s[1:0], rxd_i};
         xck_s <= {xck_s[1:0], xck_i};
         if (rxd_s[1] == rxd_s[2]) rxd_f <= rxd_s[2];
         if (xck_s[1] == xck_s[2]) xck_f <= xck_s[2];
         xck_d <= xck_f;
      end
   end
   wire xck_rise = xck_f & ~xck_d;
   wire xck_fall = ~xck_f & xck_d;
   // Polarity 0: drive on rise, sample on fall; 1 swaps
   wire tx_edge = frame_r[`UFB_POL_BIT] ? xck_fall : xck_rise;
   wire rx_edge = frame_r[`UFB_POL_BIT] ? xck_rise : xck_fall;
   wire tx_en   = sync_mode ? tx_edge : bit_en_r;
   wire rx_en   = sync_mode ? rx_edge : bit_en_r;

   // Transmitter: start, data, parity, one or two stop bits
   reg [3:0]  tx_st_r;         // Transmit state
   reg [9:0]  tx_sh_r;         // Data plus parity shift
   reg [3:0]  tx_cnt_r;        // Bits left in phase
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         tx_st_r   <= ST_IDLE;
         tx_sh_r   <= 10'h000;
         tx_cnt_r  <= 4'h0;
         txd_o     <= 1'b1;
         tx_busy_o <= 1'b0;
      end else begin
         case (tx_st_r)
            ST_IDLE: begin
               txd_o <= 1'b1;
               if (tx_start_i) begin
                  // Parity over the live data bits only
                  tx_sh_r   <= {1'b0, tx_data_i & ~(9'h1FF << nbits)};
                  tx_sh_r[nbits] <= par_odd ^ (^(tx_data_i & ~(9'h1FF << nbits)));
                  tx_cnt_r  <= nbits + {3'h0, par_en};
                  tx_busy_o <= 1'b1;
                  tx_st_r   <= ST_START;
               end
            end
            ST_START: if (tx_en) begin
               txd_o   <= 1'b0;
               tx_st_r <= ST_DATA;
            end
            ST_DATA: if (tx_en) begin
               txd_o    <= tx_sh_r[0];
               tx_sh_r  <= {1'b0, tx_sh_r[9:1]};
               tx_cnt_r <= tx_cnt_r - 4'h1;
               if (tx_cnt_r == 4'h1) begin
                  tx_cnt_r <= two_stop ? 4'h2 : 4'h1;
                  tx_st_r  <= ST_STOP;
               end
            end
            ST_STOP: if (tx_en) begin
               txd_o    <= 1'b1;
               tx_cnt_r <= tx_cnt_r - 4'h1;
               if (tx_cnt_r == 4'h0) begin
                  tx_busy_o <= 1'b0;
                  tx_st_r   <= ST_IDLE;
               end
            end
            default: tx_st_r <= ST_IDLE;
         endcase
      end
   end

   // Receiver: one stop bit always; stop select not consulted
   reg [3:0] rx_st_r;          // Receive state
   reg [8:0] rx_sh_r;          // Collected data bits
   reg [3:0] rx_cnt_r;         // Bits received so far
   reg       rx_par_r;         // Running parity
   reg       perr_pulse;       // Parity mismatch event
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rx_st_r    <= ST_IDLE;
         rx_sh_r    <= 9'h000;
         rx_cnt_r   <= 4'h0;
         rx_par_r   <= 1'b0;
         rx_data_o  <= 9'h000;
         rx_valid_o <= 1'b0;
         perr_pulse <= 1'b0;
      end else begin
         rx_valid_o <= 1'b0;
         perr_pulse <= 1'b0;
         case (rx_st_r)
            ST_IDLE: if (rx_en && !rxd_f) begin
               rx_sh_r  <= 9'h000;
               rx_cnt_r <= 4'h0;
               rx_par_r <= par_odd;
               rx_st_r  <= ST_DATA;
            end
            ST_DATA: if (rx_en) begin
               rx_par_r <= rx_par_r ^ rxd_f;
               if (rx_cnt_r < nbits)
                  rx_sh_r[rx_cnt_r] <= rxd_f;
               rx_cnt_r <= rx_cnt_r + 4'h1;
               if (rx_cnt_r == nbits - {3'h0, ~par_en})
                  rx_st_r <= ST_STOP;
            end
            ST_STOP: if (rx_en) begin
               rx_data_o  <= rx_sh_r;
               rx_valid_o <= 1'b1;
               perr_pulse <= par_en & rx_par_r;
               rx_st_r    <= ST_IDLE;
            end
            default: rx_st_r <= ST_IDLE;
         endcase
      end
   end

   // Sticky status: set wins over write-one-clear
   wire       wr_stat = wr_b0 && wb_adr_i == `UFB_OFF_STATUS;
   wire [1:0] ev      = {reload_r, perr_pulse};
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         stat_r <= 2'h0;
         irq_o  <= 1'b0;
      end else begin
         stat_r <= (stat_r & ~(wr_stat ? wb_dat_i[1:0] : 2'h0)) | ev;
         irq_o  <= |(((stat_r & ~(wr_stat ? wb_dat_i[1:0] : 2'h0)) | ev) & mask_r);
      end
   end
endmodule // ufb_core

// [testbench/ufb_sva.sv]
// Purpose: Port-level checks on the frame/baud block
// Assumes: One clock, sync active-low reset, async and sync serial frames
// Notes:   Bound to the core from the bench top file
`timescale 1ns/1ps
module ufb_sva (
   input wire logic        mclk_i,
   input wire logic        rst_n_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [3:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        wb_err_o,
   input wire logic        tx_start_i,
   input wire logic        tx_busy_o,
   input wire logic        txd_o,
   input wire logic        rx_valid_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // Edge at which a request is taken
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   endsequence
   // A read of one offset being taken
   sequence s_rd(logic [3:0] a);
      s_take ##0 (!wb_we_i && wb_adr_i == a);
   endsequence
   property p_ack_one;
      s_take |=> (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("answer not one cycle");
   property p_ack_only;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   a_ack_only: assert property (p_ack_only) else $error("ack without request");
   property p_err_unmapped;
      s_take ##0 (wb_adr_i[1:0] != 2'h0) |=> wb_err_o && !wb_ack_o;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped acked");
   property p_frame_sel;
      s_rd(4'h0) |=> wb_ack_o && wb_dat_o[7];
   endproperty
   a_frame_sel: assert property (p_frame_sel) else $error("select bit read zero");
   property p_high_view;
      s_rd(4'hC) |=> wb_ack_o && wb_dat_o[15:12] == 4'h0;
   endproperty
   a_high_view: assert property (p_high_view) else $error("high view bits set");
   property p_idle_high;
      !tx_busy_o |-> txd_o;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("line low while idle");
   property p_start_bit;
      !tx_busy_o && tx_start_i |=> tx_busy_o && txd_o;
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("start not taken");
   property p_min_bit;
      $changed(txd_o) |=> $stable(txd_o) [*7];
   endproperty
   a_min_bit: assert property (p_min_bit) else $error("bit under 8 clocks");
   property p_rx_pulse;
      rx_valid_o |=> !rx_valid_o;
   endproperty
   a_rx_pulse: assert property (p_rx_pulse) else $error("rx valid too long");
endmodule // ufb_sva

// [testbench/ufb_peer.sv]
// Purpose: Remote async transceiver facing the serial pins
// Assumes: Bit time in clocks set by the bench before each frame
// Notes:   Line idles high, as an async link does
`timescale 1ns/1ps
module ufb_peer (
   input  wire logic mclk_i,
   input  wire logic txd_i,
   output logic      rxd_o
);
   int          bt = 16;  // Clocks per bit
   int          nb = 10;  // Bits captured after start
   logic [11:0] cap;      // Captured bits, first sent lowest
   initial rxd_o = 1'b1;
   // Capture: centre of start, then one sample per bit
   always begin
      @(negedge txd_i);
      cap = 12'h000;
      repeat (bt / 2) @(posedge mclk_i);
      for (int i = 0; i < nb; i++) begin
         repeat (bt) @(posedge mclk_i);
         cap[i] = txd_i;
      end
   end
   // Send start plus n bits; one stop keeps frames tight
   task automatic send(input logic [11:0] b, input int n);
      rxd_o <= 1'b0;
      repeat (bt) @(posedge mclk_i);
      for (int i = 0; i < n; i++) begin
         rxd_o <= b[i];
         repeat (bt) @(posedge mclk_i);
      end
   endtask
endmodule // ufb_peer

// [testbench/tb.sv]
// Purpose: Self-checking bench for the frame/baud block
// Assumes: Async frames via the peer; sync frames clocked by the bench on xck_i
// Notes:   Frames and lengths predicted with integers here
`timescale 1ns/1ps
module tb;
   logic        mclk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic        wb_ack_o, wb_err_o, tx_busy_o, txd_o, rx_valid_o, irq_o, rxd_i, e, i0;
   logic        tx_start_i = 1'b0, xck_i = 1'b0;
   logic [8:0]  tx_data_i = 9'h000, rx_data_o;
   int          n_mismatch = 0, compares = 0, cyc_cnt = 0, seed = 28346;
   int          pm[3] = '{0, 2, 3};        // Parity codes used
   int          sc[5] = '{0, 1, 2, 3, 7};  // Size codes used
   always #2 mclk_i = ~mclk_i;
   ufb_core dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .tx_start_i(tx_start_i), .tx_data_i(tx_data_i), .tx_busy_o(tx_busy_o),
      .txd_o(txd_o), .rxd_i(rxd_i), .xck_i(xck_i), .rx_data_o(rx_data_o),
      .rx_valid_o(rx_valid_o), .irq_o(irq_o));
   ufb_peer peer (.mclk_i(mclk_i), .txd_i(txd_o), .rxd_o(rxd_i));
   task end_sim;
      if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // Classic cycle held until the answer; no fixed latency assumed
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hF);
      int k;
      k = 0;
      @(posedge mclk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
      {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, d};
      do begin
         @(posedge mclk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 20);
      if (k >= 20) n_mismatch++;
      q = wb_dat_o;
      e = wb_err_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask
   // Full format and divisor; low byte last so it reloads
   task automatic cfg(input int par, stp, sz, dbl, div);
      wb(1, 4'h0, {24'h0, 2'h2, par[1:0], stp[0], sz[1:0], 1'b0});
      wb(1, 4'h8, {30'h0, sz[2], dbl[0]});
      wb(1, 4'h0, {28'h0, div[11:8]});
      wb(1, 4'h4, {24'h0, div[7:0]});
   endtask
   // One transmitted frame checked bit by bit and by length
   task automatic tx_one(input int par, stp, sz, dbl);
      int div, n, p, bt, d, ex, nb, dur;
      div = $random(seed) & 1;
      n = (sz == 7) ? 9 : sz + 5;
      p = par[1];
      bt = (div + 1) * (dbl ? 8 : 16);
      cfg(par, stp, sz, dbl, div);
      d = $random(seed) & ((1 << n) - 1);
      ex = d;
      if (p && ((^d[8:0]) ^ par[0])) ex |= 1 << n;
      nb = n + p + stp + 1;
      ex = (ex | (3 << (n + p))) & ((1 << nb) - 1);
      peer.bt = bt;
      peer.nb = nb;
      @(posedge mclk_i);
      tx_data_i <= d[8:0];
      tx_start_i <= 1'b1;
      @(posedge mclk_i);
      tx_start_i <= 1'b0;
      dur = 0;
      // Start bit waits for the next bit enable, so length counts from it
      while (txd_o !== 1'b0 && dur < 8000) begin
         @(posedge mclk_i);
         dur++;
      end
      dur = 0;
      do begin
         @(posedge mclk_i);
         dur++;
      end while (tx_busy_o === 1'b1 && dur < 8000);
      repeat (bt) @(posedge mclk_i);
      chk("tx frame", peer.cap, ex);
      chk("tx length", (dur + bt / 2) / bt, nb + 1);
   endtask
   // One received frame, parity good or broken on purpose
   task automatic rx_one(input int par, bad);
      int d, b, k, p;
      p = par[1];
      d = $random(seed) & 32'hFF;
      b = d | (1 << (8 + p));
      if (p && ((^d[7:0]) ^ par[0] ^ bad[0])) b |= 1 << 8;
      k = 0;
      fork
         peer.send(b[11:0], 9 + p);
         begin
            do begin
               @(posedge mclk_i);
               k++;
            end while (rx_valid_o !== 1'b1 && k < 4000);
            chk("rx data", rx_data_o, d);
         end
      join
      wb(0, 4'hC, 32'h0);
      chk("parity flag", q[0], p & bad);
      wb(1, 4'hC, 32'h3);
   endtask
   // Synchronous frame, bench clock of 16 cycles, still outside the frame
   task automatic tx_sync(input int pol);
      int d, cap;
      d = $random(seed) & 32'hFF;
      cap = 0;
      wb(1, 4'h8, 32'h0);
      wb(1, 4'h0, 32'hC6 | pol);
      @(posedge mclk_i);
      xck_i <= pol[0];
      tx_data_i <= d[8:0];
      tx_start_i <= 1'b1;
      @(posedge mclk_i);
      tx_start_i <= 1'b0;
      // Launch edge first, line read at the opposite edge
      for (int i = 0; i < 11; i++) begin
         repeat (8) @(posedge mclk_i);
         xck_i <= ~pol[0];
         repeat (8) @(posedge mclk_i);
         xck_i <= pol[0];
         cap[i] = txd_o;
      end
      chk("sync frame", cap, (d << 1) | 32'h600);
      chk("sync done", tx_busy_o, 32'h0);
   endtask
   // Hang guard, well above the expected run
   always @(posedge mclk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 80000) begin
         n_mismatch++;
         end_sim;
      end
   end
   initial begin
      repeat (5) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      wb(0, 4'h0, 32'h0);
      chk("frame reset", q[7:0], 8'h86);
      wb(0, 4'hC, 32'h0);
      chk("status reset", q[15:0], 16'h0000);
      wb(1, 4'h0, 32'h0000000F);
      wb(0, 4'hC, 32'h0);
      chk("div high", q[15:8], 8'h0F);
      wb(0, 4'h0, 32'h0);
      chk("frame kept", q[7:0], 8'h86);
      wb(1, 4'h0, 32'h000000B4);
      wb(0, 4'h0, 32'h0);
      chk("frame write", q[7:0], 8'hB4);
      wb(1, 4'h4, 32'h000000A5);
      wb(1, 4'h4, 32'h0000005A, 4'hE);
      wb(0, 4'h4, 32'h0);
      chk("div low", q[7:0], 8'hA5);
      wb(0, 4'hC, 32'h0);
      chk("reload flag", q[15:0], 16'h0F02);
      wb(1, 4'h8, 32'h0);
      repeat (2) @(posedge mclk_i);
      i0 = irq_o;
      wb(1, 4'h8, 32'h30);
      repeat (2) @(posedge mclk_i);
      chk("irq mask", i0 ^ irq_o, 32'h1);
      wb(1, 4'hC, 32'h2);
      repeat (2) @(posedge mclk_i);
      chk("irq clear", irq_o, 32'h0);
      wb(0, 4'hC, 32'h0);
      chk("flag clear", q[1], 32'h0);
      wb(0, 4'h1, 32'h0);
      chk("unmapped", e, 32'h1);
      for (int c = 0; c < 60; c++)
         tx_one(pm[c % 3], (c / 3) % 2, sc[(c / 6) % 5], c / 30);
      peer.bt = 16;
      for (int r = 0; r < 6; r++) begin
         cfg(pm[r % 3], 1, 3, 0, 0);
         rx_one(pm[r % 3], r / 3);
      end
      tx_sync(0);
      tx_sync(1);
      end_sim;
   end
endmodule // tb
bind ufb_core ufb_sva chk_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .tx_start_i(tx_start_i),
   .tx_busy_o(tx_busy_o), .txd_o(txd_o), .rx_valid_o(rx_valid_o));
